// [core/ldup_pkg.sv]
// Function
// - codes 0..5 give 1..32 period intervals
// - codes 6 and 7 act as 32
// - one pwm period is 4096 dimming clocks
// - reg 0x1B holds leds 8,7,6 fields
// - reg 0x1C holds leds 11,10,9 fields
// - leds 5,4,3 fields at 10:8,6:4,2:0
// - interval registers read back last written codes
// - duty is 12-bit, 0 off, FFF on
package ldup_pkg;
  localparam int          NUM_LEDS      = 12;
  localparam int          CODE_W        = 3;
  localparam int          DUTY_W        = 12;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 13;
  localparam int          PERIOD_CYCLES = 4096;
  localparam int          MAX_INTERVAL  = 32;
  localparam logic [7:0]  OFFS_LEDS_2_1_0   = 8'h19;
  localparam logic [7:0]  OFFS_LEDS_5_4_3   = 8'h1A;
  localparam logic [7:0]  OFFS_LEDS_8_7_6   = 8'h1B;
  localparam logic [7:0]  OFFS_LEDS_11_10_9 = 8'h1C;
  localparam int          FIELD_LO_POS  = 0;
  localparam int          FIELD_MID_POS = 4;
  localparam int          FIELD_HI_POS  = 8;
  localparam logic [2:0]  CODE_RESET    = 3'h0;
  localparam logic [2:0]  CODE_LAST     = 3'h5;
  localparam logic [11:0] DUTY_RESET    = 12'h000;

  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ldup_reg_req_t;

  typedef struct packed {
    logic              rd_valid;
    logic [DATA_W-1:0] rdata;
  } ldup_reg_rsp_t;
endpackage : ldup_pkg

// [core/ldup_channel.sv]
`timescale 1ns/1ns
module ldup_channel (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        period_end_i,
  input  wire logic [2:0]  code_i,
  input  wire logic [11:0] pend_duty_i,
  output logic      [11:0] duty_o,
  output logic             update_o
);
  logic [4:0] count_reg;
  logic [4:0] limit;

  // saturating decode keeps the counter at 5 bits
  always_comb
  begin
    if (code_i > ldup_pkg::CODE_LAST)
      limit = 5'(ldup_pkg::MAX_INTERVAL - 1);
    else
      limit = 5'((1 << code_i) - 1);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      count_reg <= 5'h00;
      duty_o    <= ldup_pkg::DUTY_RESET;
      update_o  <= 1'b0;
    end
    else
    begin
      update_o <= 1'b0;
      if (period_end_i)
      begin
        // >= so a shortened code takes effect at once
        if (count_reg >= limit)
        begin
          count_reg <= 5'h00;
          duty_o    <= pend_duty_i;
          update_o  <= 1'b1;
        end
        else
          count_reg <= count_reg + 5'h01;
      end
    end
  end
endmodule : ldup_channel

// [core/ldup_top.sv]
`timescale 1ns/1ns
module ldup_top #(
  parameter int PERIOD_CYCLES = ldup_pkg::PERIOD_CYCLES
) (
  input  wire logic                    clock_i,
  input  wire logic                    rstn_i,
  input  wire ldup_pkg::ldup_reg_req_t reg_req_i,
  output ldup_pkg::ldup_reg_rsp_t      reg_rsp_o,
  input  wire logic [12*12-1:0]        pend_duty_i,
  output logic      [12*12-1:0]        duty_o,
  output logic      [11:0]             update_o,
  output logic                         period_end_o
);
  localparam int NL   = ldup_pkg::NUM_LEDS;
  localparam int CW   = ldup_pkg::CODE_W;
  localparam int DW   = ldup_pkg::DUTY_W;
  localparam int NREG = NL / 3;

  // the period counter is 16 bits wide and the strobe is set one count early
  if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > 65536)
  begin : g_bad_period
    $error("PERIOD_CYCLES out of range");
  end

  // ports and register fields are laid out for twelve 3-bit codes and 12-bit duties
  if (NL != 12 || CW != 3 || DW != 12 || ldup_pkg::DATA_W < 11)
  begin : g_bad_layout
    $error("field layout does not fit the ports");
  end

  logic [15:0]     pcnt_reg;
  logic [15:0]     pcnt_next;
  logic            wrap;
  logic            hit;
  logic [1:0]      sel;
  logic [NREG-1:0] wr_sel;
  logic            rd_hit;
  logic [12:0]     rd_word;
  logic [CW-1:0]   code_arr [NL];

  logic [CW-1:0]   led0_update_interval_reg;
  logic [CW-1:0]   led1_update_interval_reg;
  logic [CW-1:0]   led2_update_interval_reg;
  logic [CW-1:0]   led3_update_interval_reg;
  logic [CW-1:0]   led4_update_interval_reg;
  logic [CW-1:0]   led5_update_interval_reg;
  logic [CW-1:0]   led6_update_interval_reg;
  logic [CW-1:0]   led7_update_interval_reg;
  logic [CW-1:0]   led8_update_interval_reg;
  logic [CW-1:0]   led9_update_interval_reg;
  logic [CW-1:0]   led10_update_interval_reg;
  logic [CW-1:0]   led11_update_interval_reg;

  // one extractor keeps the three slots at the same bits in every register
  function automatic logic [2:0] field_at(input logic [12:0] word, input int pos);
    return word[pos +: 3];
  endfunction : field_at

  // address decode, shared by the write and the read path
  always_comb
  begin
    hit = 1'b1;
    sel = 2'h0;
    case (reg_req_i.addr)
      ldup_pkg::OFFS_LEDS_2_1_0:   sel = 2'h0;
      ldup_pkg::OFFS_LEDS_5_4_3:   sel = 2'h1;
      ldup_pkg::OFFS_LEDS_8_7_6:   sel = 2'h2;
      ldup_pkg::OFFS_LEDS_11_10_9: sel = 2'h3;
      default:                     hit = 1'b0;
    endcase
  end

  // writes to unmapped offsets select no register and are dropped
  always_comb
  begin
    wr_sel = '0;
    if (reg_req_i.wr_en && hit)
      wr_sel[sel] = 1'b1;
  end

  assign rd_hit = reg_req_i.rd_en && hit;

  // period counter: one boundary strobe every PERIOD_CYCLES clocks
  always_comb
  begin
    wrap = (pcnt_reg == 16'(PERIOD_CYCLES - 1));
    if (wrap)
      pcnt_next = 16'h0000;
    else
      pcnt_next = pcnt_reg + 16'h0001;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      pcnt_reg <= 16'h0000;
    else
      pcnt_reg <= pcnt_next;
  end

  // strobe registered one count early so it stands in the wrap cycle
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      period_end_o <= 1'b0;
    else
      period_end_o <= (pcnt_reg == 16'(PERIOD_CYCLES - 2));
  end

  // leds 2, 1, 0
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      led0_update_interval_reg <= ldup_pkg::CODE_RESET;
      led1_update_interval_reg <= ldup_pkg::CODE_RESET;
      led2_update_interval_reg <= ldup_pkg::CODE_RESET;
    end
    else if (wr_sel[0])
    begin
      led0_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_LO_POS);
      led1_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_MID_POS);
      led2_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_HI_POS);
    end
  end

  // leds 5, 4, 3
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      led3_update_interval_reg <= ldup_pkg::CODE_RESET;
      led4_update_interval_reg <= ldup_pkg::CODE_RESET;
      led5_update_interval_reg <= ldup_pkg::CODE_RESET;
    end
    else if (wr_sel[1])
    begin
      led3_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_LO_POS);
      led4_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_MID_POS);
      led5_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_HI_POS);
    end
  end

  // leds 8, 7, 6
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      led6_update_interval_reg <= ldup_pkg::CODE_RESET;
      led7_update_interval_reg <= ldup_pkg::CODE_RESET;
      led8_update_interval_reg <= ldup_pkg::CODE_RESET;
    end
    else if (wr_sel[2])
    begin
      led6_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_LO_POS);
      led7_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_MID_POS);
      led8_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_HI_POS);
    end
  end

  // leds 11, 10, 9
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      led9_update_interval_reg  <= ldup_pkg::CODE_RESET;
      led10_update_interval_reg <= ldup_pkg::CODE_RESET;
      led11_update_interval_reg <= ldup_pkg::CODE_RESET;
    end
    else if (wr_sel[3])
    begin
      led9_update_interval_reg  <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_LO_POS);
      led10_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_MID_POS);
      led11_update_interval_reg <= field_at(reg_req_i.wdata, ldup_pkg::FIELD_HI_POS);
    end
  end

  // the channels see the codes as one array, indexed by led number
  assign code_arr[0]  = led0_update_interval_reg;
  assign code_arr[1]  = led1_update_interval_reg;
  assign code_arr[2]  = led2_update_interval_reg;
  assign code_arr[3]  = led3_update_interval_reg;
  assign code_arr[4]  = led4_update_interval_reg;
  assign code_arr[5]  = led5_update_interval_reg;
  assign code_arr[6]  = led6_update_interval_reg;
  assign code_arr[7]  = led7_update_interval_reg;
  assign code_arr[8]  = led8_update_interval_reg;
  assign code_arr[9]  = led9_update_interval_reg;
  assign code_arr[10] = led10_update_interval_reg;
  assign code_arr[11] = led11_update_interval_reg;

  // read mux: unmapped reads and the spare bits stay zero
  always_comb
  begin
    rd_word = 13'h0000;
    if (rd_hit)
    begin
      case (sel)
        2'h0:
        begin
          rd_word[ldup_pkg::FIELD_LO_POS  +: 3] = led0_update_interval_reg;
          rd_word[ldup_pkg::FIELD_MID_POS +: 3] = led1_update_interval_reg;
          rd_word[ldup_pkg::FIELD_HI_POS  +: 3] = led2_update_interval_reg;
        end
        2'h1:
        begin
          rd_word[ldup_pkg::FIELD_LO_POS  +: 3] = led3_update_interval_reg;
          rd_word[ldup_pkg::FIELD_MID_POS +: 3] = led4_update_interval_reg;
          rd_word[ldup_pkg::FIELD_HI_POS  +: 3] = led5_update_interval_reg;
        end
        2'h2:
        begin
          rd_word[ldup_pkg::FIELD_LO_POS  +: 3] = led6_update_interval_reg;
          rd_word[ldup_pkg::FIELD_MID_POS +: 3] = led7_update_interval_reg;
          rd_word[ldup_pkg::FIELD_HI_POS  +: 3] = led8_update_interval_reg;
        end
        2'h3:
        begin
          rd_word[ldup_pkg::FIELD_LO_POS  +: 3] = led9_update_interval_reg;
          rd_word[ldup_pkg::FIELD_MID_POS +: 3] = led10_update_interval_reg;
          rd_word[ldup_pkg::FIELD_HI_POS  +: 3] = led11_update_interval_reg;
        end
        default: rd_word = 13'h0000;
      endcase
    end
  end

  // a write and a read in one cycle answer the old codes
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      reg_rsp_o.rd_valid <= 1'b0;
      reg_rsp_o.rdata    <= 13'h0000;
    end
    else
    begin
      reg_rsp_o.rd_valid <= reg_req_i.rd_en;
      reg_rsp_o.rdata    <= rd_word;
    end
  end

  for (genvar i = 0; i < NL; i++)
  begin : g_ch
    ldup_channel u_ch (
      .clock_i      (clock_i),
      .rstn_i       (rstn_i),
      .period_end_i (period_end_o),
      .code_i       (code_arr[i]),
      .pend_duty_i  (pend_duty_i[12*i +: 12]),
      .duty_o       (duty_o[12*i +: 12]),
      .update_o     (update_o[i])
    );
  end
endmodule : ldup_top

// [verification/ldup_host.sv]
`timescale 1ns/1ns
module ldup_host (
  input  wire logic               clock_i,
  output ldup_pkg::ldup_reg_req_t req_o
);
  initial req_o = '0;
  // one-cycle request, then an idle cycle so no edge sees a stale request
  task automatic acc(input logic w, input logic [7:0] a, input logic [12:0] d);
  begin
    @(negedge clock_i);
    req_o = {w, !w, a, d};
    @(negedge clock_i);
    req_o = '0;
  end
  endtask : acc
endmodule : ldup_host

// [verification/ldup_props.sv]
`timescale 1ns/1ns
module ldup_props #(parameter int PERIOD_CYCLES = ldup_pkg::PERIOD_CYCLES) (
  input wire logic                    clock_i,
  input wire logic                    rstn_i,
  input wire ldup_pkg::ldup_reg_req_t reg_req_i,
  input wire ldup_pkg::ldup_reg_rsp_t reg_rsp_o,
  input wire logic [143:0]            pend_duty_i,
  input wire logic [143:0]            duty_o,
  input wire logic [11:0]             update_o,
  input wire logic                    period_end_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_rd_answer: assert property (reg_rsp_o.rd_valid == $past(reg_req_i.rd_en)) else $error("bad answer");
  a_spare_zero: assert property (reg_rsp_o.rd_valid |-> (reg_rsp_o.rdata & 13'h1888) == 13'h0000)
    else $error("spare bit set");
  a_unmapped_zero: assert property (reg_req_i.rd_en && !(reg_req_i.addr inside {[8'h19:8'h1C]}) |=>
    reg_rsp_o.rdata == 13'h0000) else $error("unmapped data");
  a_wr_rd_back: assert property (reg_req_i.wr_en && reg_req_i.addr == 8'h1C ##2 reg_req_i.rd_en &&
    reg_req_i.addr == 8'h1C |=> reg_rsp_o.rdata == ($past(reg_req_i.wdata, 3) & 13'h0777)) else $error("readback");
  // edges since the last strobe or reset; a counter, since a period is far longer than a delay may be
  logic [16:0] gap_cnt;
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || period_end_o)
      gap_cnt <= 17'h00000;
    else
      gap_cnt <= gap_cnt + 17'h00001;
  end
  a_period_len: assert property (period_end_o == (gap_cnt == 17'(PERIOD_CYCLES - 1))) else $error("period");
  a_upd_boundary: assert property (|update_o |-> $past(period_end_o)) else $error("update off boundary");
  a_duty_load: assert property (update_o[6] |-> duty_o[83:72] == $past(pend_duty_i[83:72]))
    else $error("duty load");
  a_duty_hold: assert property (!update_o[6] |-> $stable(duty_o[83:72])) else $error("duty moved");
endmodule : ldup_props
bind ldup_top ldup_props #(.PERIOD_CYCLES(PERIOD_CYCLES)) ldup_props_inst (.clock_i, .rstn_i, .reg_req_i,
  .reg_rsp_o, .pend_duty_i, .duty_o, .update_o, .period_end_o);

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
  logic                    clock_i = 1'b0;
  logic                    rstn_i  = 1'b0;
  ldup_pkg::ldup_reg_req_t req;
  ldup_pkg::ldup_reg_rsp_t rsp;
  logic [143:0]            pend = '0;
  logic [143:0]            duty;
  logic [11:0]             upd;
  logic [12:0]             v;
  logic [7:0]              a;
  int                      error_cnt = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  int                      n;
  int                      rw[10][3] = '{'{6,0,1}, '{7,1,2}, '{8,2,4}, '{9,3,8}, '{10,4,16}, '{11,5,32},
                                         '{3,6,32}, '{5,7,32}, '{1,1,2}, '{4,2,4}};
  initial forever #20 clock_i = ~clock_i;
  ldup_host ldup_host_inst (.clock_i(clock_i), .req_o(req));
  ldup_top #(.PERIOD_CYCLES(16)) ldup_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(req),
    .reg_rsp_o(rsp), .pend_duty_i(pend), .duty_o(duty), .update_o(upd), .period_end_o());
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask : chk
  task automatic wt(input int led);
  begin
    @(negedge clock_i);
    for (n = 1; n < 999 && upd[led] !== 1'b1; n++) @(negedge clock_i);
  end
  endtask : wt
  task automatic rd(input logic [7:0] ad, input logic [15:0] exp);
  begin
    ldup_host_inst.acc(1'b0, ad, 13'h0000);
    chk("read", {rsp.rd_valid, rsp.rdata}, exp);
  end
  endtask : rd
  task automatic test_done;
  begin
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask : test_done
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 15000)
    begin
      error_cnt++;
      test_done;
    end
  end
  initial
  begin
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    rd(8'h1B, 16'h2000);
    foreach (rw[r])
    begin
      pend[rw[r][0]*12 +: 12] = 12'hA50 + 12'(r);
      a = 8'h19 + 8'(rw[r][0] / 3);
      v = 13'(rw[r][1]) << (rw[r][0] % 3 * 4);
      ldup_host_inst.acc(1'b1, a, v);
      rd(a, 16'h2000 | 16'(v));
      wt(rw[r][0]);
      chk("duty", 16'(duty[rw[r][0]*12 +: 12]), 16'hA50 + 16'(r));
      wt(rw[r][0]);
      chk("gap", 16'(n), 16'(rw[r][2] * 16));
    end
    ldup_host_inst.acc(1'b1, 8'h1C, 13'h1FFF);
    rd(8'h1C, 16'h2777);
    ldup_host_inst.acc(1'b1, 8'h1D, 13'h0111);
    rd(8'h1D, 16'h2000);
    // reset held two edges so the duty hold check never straddles it
    rstn_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rstn_i = 1'b1;
    rd(8'h1C, 16'h2000);
    chk("duty", 16'(duty[143:132]), 16'h0000);
    test_done;
  end
endmodule : tb
